// ==== verilog/tvm_display_regs.sv ====
`timescale 1ns/1ns
`include "tvm_regs.svh"
// What this block does
// - 8-bit RW mode register at 00H: resolution 7:5, standard 4:3, scaling 2:0
// - Mode register resets to 640x480, NTSC, 7/8 scaling
// - Resolution code decodes to six input formats, 101 interlaced
// - Standard code selects PAL, NTSC, PAL-M or NTSC-J
// - Scaling code selects 5/4, 1/1, 7/8, 5/6, 3/4 or 7/10
// - Only 27 listed code combinations are valid modes, numbered 0 to 26
// - Each mode has its own line and frame totals and pixel clock
// - Modes 25 and 26 are interlaced 1/1 at 13.5 MHz, bypassing some functions
// - 6-bit RW filter register at 01H, reset chroma 11, luma 00, text 10
// - Chroma field sits in bits 5:4 on write and read
// - Writes take luma from bits 3:2 and text from bits 1:0
// - Reads return luma in bits 1:0 and text in bits 3:2
// - Luma field: minimal, slight, maximum; 11 invalid
// - Text field: maximum, slight, minimum enhancement; 11 invalid
// - Chroma field: minimal, slight, maximum flicker filtering
// - Chroma code 11 enables dot crawl reduction instead
module tvm_display_regs
  import tvm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output tvm_res_t input_resolution_code,
  output tvm_std_t output_standard_code,
  output tvm_scale_t scaling_ratio_code,
  output logic mode_valid,
  output logic [4:0] mode_number,
  output logic interlaced_mode,
  output logic [10:0] pixels_per_line,
  output logic [9:0] lines_per_frame,
  output logic [15:0] pixel_clock_khz,
  output tvm_flt_t chroma_filter_field,
  output tvm_flt_t luma_filter_field,
  output tvm_flt_t text_enhance_field,
  output logic dot_crawl_reduce,
  output logic filter_code_invalid
);
  logic rst_meta;
  logic rst_sync_n;
  logic [7:0] display_mode_select;
  logic [5:0] flicker_filter_control;
  logic next_valid;
  logic [4:0] next_number;
  logic [10:0] next_ppl;
  logic [9:0] next_lpf;
  logic [15:0] next_pclk;
  logic [7:0] next_rdata;
  tvm_res_t next_res;
  tvm_std_t next_std;
  tvm_scale_t next_scale;

  // Reset released through two flops so release is clean on ref_clk
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      display_mode_select <= `TVM_MODE_RESET;
    else if (reg_wr && reg_addr == `TVM_ADDR_MODE)
      display_mode_select <= reg_wdata;
  end

  // Stored in write layout; read path swaps luma and text
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      flicker_filter_control <= `TVM_FILTER_RESET;
    else if (reg_wr && reg_addr == `TVM_ADDR_FILTER)
      flicker_filter_control <= reg_wdata[5:0];
  end

  tvm_mode_decode u_decode (
    .mode_code(display_mode_select),
    .res_code(next_res),
    .std_code(next_std),
    .scale_code(next_scale)
  );

  // Labels are the whole mode byte; unlisted triples give zero totals
  always_comb
  begin
    next_valid = 1'b1;
    next_number = 5'h00;
    next_ppl = 11'h000;
    next_lpf = 10'h000;
    next_pclk = 16'h0000;
    case (display_mode_select)
      8'h00:
      begin
        next_number = 5'h00;
        {next_ppl, next_lpf, next_pclk} = {11'h348, 10'h1f4, 16'h5208};
      end
      8'h01:
      begin
        next_number = 5'h01;
        {next_ppl, next_lpf, next_pclk} = {11'h348, 10'h271, 16'h668a};
      end
      8'h08:
      begin
        next_number = 5'h02;
        {next_ppl, next_lpf, next_pclk} = {11'h320, 10'h1a4, 16'h4eac};
      end
      8'h09:
      begin
        next_number = 5'h03;
        {next_ppl, next_lpf, next_pclk} = {11'h310, 10'h20d, 16'h605f};
      end
      8'h20:
      begin
        next_number = 5'h04;
        {next_ppl, next_lpf, next_pclk} = {11'h465, 10'h1f4, 16'h6ddd};
      end
      8'h21:
      begin
        next_number = 5'h05;
        {next_ppl, next_lpf, next_pclk} = {11'h45c, 10'h271, 16'h883b};
      end
      8'h28:
      begin
        next_number = 5'h06;
        {next_ppl, next_lpf, next_pclk} = {11'h3b1, 10'h1a4, 16'h5cee};
      end
      8'h29:
      begin
        next_number = 5'h07;
        {next_ppl, next_lpf, next_pclk} = {11'h3a8, 10'h20d, 16'h730f};
      end
      8'h40:
      begin
        next_number = 5'h08;
        {next_ppl, next_lpf, next_pclk} = {11'h3e8, 10'h1f4, 16'h61a8};
      end
      8'h41:
      begin
        next_number = 5'h09;
        {next_ppl, next_lpf, next_pclk} = {11'h3f0, 10'h271, 16'h7b0c};
      end
      8'h48:
      begin
        next_number = 5'h0a;
        {next_ppl, next_lpf, next_pclk} = {11'h348, 10'h1a4, 16'h529b};
      end
      8'h49:
      begin
        next_number = 5'h0b;
        {next_ppl, next_lpf, next_pclk} = {11'h348, 10'h20d, 16'h6742};
      end
      8'h4a:
      begin
        next_number = 5'h0c;
        {next_ppl, next_lpf, next_pclk} = {11'h348, 10'h258, 16'h7602};
      end
      8'h60:
      begin
        next_number = 5'h0d;
        {next_ppl, next_lpf, next_pclk} = {11'h348, 10'h1f4, 16'h5208};
      end
      8'h61:
      begin
        next_number = 5'h0e;
        {next_ppl, next_lpf, next_pclk} = {11'h348, 10'h271, 16'h668a};
      end
      8'h63:
      begin
        next_number = 5'h0f;
        {next_ppl, next_lpf, next_pclk} = {11'h348, 10'h2ee, 16'h7b0c};
      end
      8'h69:
      begin
        next_number = 5'h10;
        {next_ppl, next_lpf, next_pclk} = {11'h310, 10'h20d, 16'h605f};
      end
      8'h6a:
      begin
        next_number = 5'h11;
        {next_ppl, next_lpf, next_pclk} = {11'h310, 10'h258, 16'h6e24};
      end
      8'h6b:
      begin
        next_number = 5'h12;
        {next_ppl, next_lpf, next_pclk} = {11'h320, 10'h276, 16'h7602};
      end
      8'h81:
      begin
        next_number = 5'h13;
        {next_ppl, next_lpf, next_pclk} = {11'h3b0, 10'h271, 16'h733c};
      end
      8'h83:
      begin
        next_number = 5'h14;
        {next_ppl, next_lpf, next_pclk} = {11'h3c0, 10'h2ee, 16'h8ca0};
      end
      8'h84:
      begin
        next_number = 5'h15;
        {next_ppl, next_lpf, next_pclk} = {11'h3a8, 10'h344, 16'h9858};
      end
      8'h8b:
      begin
        next_number = 5'h16;
        {next_ppl, next_lpf, next_pclk} = {11'h410, 10'h276, 16'h9969};
      end
      8'h8c:
      begin
        next_number = 5'h17;
        {next_ppl, next_lpf, next_pclk} = {11'h410, 10'h2bc, 16'haa74};
      end
      8'h8d:
      begin
        next_number = 5'h18;
        {next_ppl, next_lpf, next_pclk} = {11'h428, 10'h2ee, 16'hbad8};
      end
      8'ha1:
      begin
        next_number = 5'h19;
        {next_ppl, next_lpf, next_pclk} = {11'h360, 10'h271, 16'h34bc};
      end
      8'ha9:
      begin
        next_number = 5'h1a;
        {next_ppl, next_lpf, next_pclk} = {11'h35a, 10'h20d, 16'h34bc};
      end
      default:
        next_valid = 1'b0;
    endcase
  end

  always_comb
  begin
    case (reg_addr)
      `TVM_ADDR_MODE: next_rdata = display_mode_select;
      `TVM_ADDR_FILTER: next_rdata = {2'b00,
        flicker_filter_control[`TVM_CHR_MSB:`TVM_CHR_LSB],
        flicker_filter_control[`TVM_WR_TEXT_MSB:`TVM_WR_TEXT_LSB],
        flicker_filter_control[`TVM_WR_LUMA_MSB:`TVM_WR_LUMA_LSB]};
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data registered: valid one edge after the address is presented
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end

  // Mode outputs; downstream relies on software keeping to listed modes
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      input_resolution_code <= TVM_RES_640X480;
      output_standard_code <= TVM_STD_NTSC;
      scaling_ratio_code <= TVM_SCL_7_8;
      mode_valid <= 1'b1;
      mode_number <= 5'h11;
      interlaced_mode <= 1'b0;
      pixels_per_line <= 11'h310;
      lines_per_frame <= 10'h258;
      pixel_clock_khz <= 16'h6e24;
    end
    else
    begin
      input_resolution_code <= next_res;
      output_standard_code <= next_std;
      scaling_ratio_code <= next_scale;
      mode_valid <= next_valid;
      mode_number <= next_number;
      interlaced_mode <= next_valid && (next_number == 5'h19 || next_number == 5'h1a);
      pixels_per_line <= next_ppl;
      lines_per_frame <= next_lpf;
      pixel_clock_khz <= next_pclk;
    end
  end

  // Filter settings; chroma 11 turns on dot crawl reduction
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      chroma_filter_field <= TVM_FLT_SPECIAL;
      luma_filter_field <= TVM_FLT_MIN;
      text_enhance_field <= TVM_FLT_MAX;
      dot_crawl_reduce <= 1'b1;
      filter_code_invalid <= 1'b0;
    end
    else
    begin
      chroma_filter_field <= tvm_flt_t'(flicker_filter_control[`TVM_CHR_MSB:`TVM_CHR_LSB]);
      luma_filter_field <= tvm_flt_t'(flicker_filter_control[`TVM_WR_LUMA_MSB:`TVM_WR_LUMA_LSB]);
      text_enhance_field <= tvm_flt_t'(flicker_filter_control[`TVM_WR_TEXT_MSB:`TVM_WR_TEXT_LSB]);
      dot_crawl_reduce <= &flicker_filter_control[`TVM_CHR_MSB:`TVM_CHR_LSB];
      filter_code_invalid <= &flicker_filter_control[`TVM_WR_LUMA_MSB:`TVM_WR_LUMA_LSB] ||
        &flicker_filter_control[`TVM_WR_TEXT_MSB:`TVM_WR_TEXT_LSB];
    end
  end
endmodule : tvm_display_regs

// ==== verilog/tvm_regs.svh ====
`ifndef TVM_REGS_SVH
`define TVM_REGS_SVH
`define TVM_ADDR_MODE 6'h00
`define TVM_ADDR_FILTER 6'h01
`define TVM_MODE_RESET 8'h6a
`define TVM_FILTER_RESET 6'h32
`define TVM_RES_MSB 7
`define TVM_RES_LSB 5
`define TVM_STD_MSB 4
`define TVM_STD_LSB 3
`define TVM_SCL_MSB 2
`define TVM_SCL_LSB 0
`define TVM_CHR_MSB 5
`define TVM_CHR_LSB 4
`define TVM_WR_LUMA_MSB 3
`define TVM_WR_LUMA_LSB 2
`define TVM_WR_TEXT_MSB 1
`define TVM_WR_TEXT_LSB 0
`define TVM_MODE_COUNT 27
`endif

// ==== verilog/tvm_pkg.sv ====
package tvm_pkg;
  typedef enum logic [2:0] {
    TVM_RES_512X384, TVM_RES_720X400, TVM_RES_640X400, TVM_RES_640X480,
    TVM_RES_800X600, TVM_RES_720_INTERLACED, TVM_RES_BAD6, TVM_RES_BAD7
  } tvm_res_t;
  typedef enum logic [1:0] {TVM_STD_PAL, TVM_STD_NTSC, TVM_STD_PAL_M, TVM_STD_NTSC_J} tvm_std_t;
  typedef enum logic [2:0] {
    TVM_SCL_5_4, TVM_SCL_1_1, TVM_SCL_7_8, TVM_SCL_5_6, TVM_SCL_3_4, TVM_SCL_7_10,
    TVM_SCL_BAD6, TVM_SCL_BAD7
  } tvm_scale_t;
  typedef enum logic [1:0] {TVM_FLT_MIN, TVM_FLT_SLIGHT, TVM_FLT_MAX, TVM_FLT_SPECIAL} tvm_flt_t;
endpackage : tvm_pkg

// ==== verilog/tvm_mode_decode.sv ====
`timescale 1ns/1ns
`include "tvm_regs.svh"
// Splits the mode byte into its three typed code fields
module tvm_mode_decode
  import tvm_pkg::*;
(
  input wire logic [7:0] mode_code,
  output tvm_res_t res_code,
  output tvm_std_t std_code,
  output tvm_scale_t scale_code
);
  assign res_code = tvm_res_t'(mode_code[`TVM_RES_MSB:`TVM_RES_LSB]);
  assign std_code = tvm_std_t'(mode_code[`TVM_STD_MSB:`TVM_STD_LSB]);
  assign scale_code = tvm_scale_t'(mode_code[`TVM_SCL_MSB:`TVM_SCL_LSB]);
endmodule : tvm_mode_decode

// ==== test/tvm_display_regs_assertions.sv ====
`timescale 1ns/1ns
module tvm_display_regs_assertions
  import tvm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire tvm_res_t input_resolution_code,
  input wire tvm_std_t output_standard_code,
  input wire tvm_scale_t scaling_ratio_code,
  input wire logic mode_valid,
  input wire logic [4:0] mode_number,
  input wire logic interlaced_mode,
  input wire logic [10:0] pixels_per_line,
  input wire logic [9:0] lines_per_frame,
  input wire logic [15:0] pixel_clock_khz,
  input wire tvm_flt_t chroma_filter_field,
  input wire tvm_flt_t luma_filter_field,
  input wire tvm_flt_t text_enhance_field,
  input wire logic dot_crawl_reduce,
  input wire logic filter_code_invalid
);
  // Internal reset trails rst_n by two edges, so reads are judged only later
  logic [2:0] up_cnt;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      up_cnt <= 3'h0;
    else if (up_cnt != 3'h7)
      up_cnt <= up_cnt + 3'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_mode; reg_wr && reg_addr == 6'h00 ##1 !reg_wr; endsequence
  sequence s_wr_flt; reg_wr && reg_addr == 6'h01 ##1 !reg_wr; endsequence
  a_mode_write_fields: assert property (s_wr_mode |=> {input_resolution_code,
    output_standard_code, scaling_ratio_code} == $past(reg_wdata, 2)) else $error("mode fields");
  a_filter_write_fields: assert property (s_wr_flt |=> {chroma_filter_field,
    luma_filter_field, text_enhance_field} == $past(reg_wdata[5:0], 2)) else $error("filter fields");
  a_dot_crawl_follow: assert property (s_wr_flt |=>
    dot_crawl_reduce == (&$past(reg_wdata[5:4], 2))) else $error("dot crawl flag");
  a_code_invalid_flag: assert property (s_wr_flt |=> filter_code_invalid ==
    ((&$past(reg_wdata[3:2], 2)) || (&$past(reg_wdata[1:0], 2)))) else $error("invalid flag");
  a_filter_read_swap: assert property ((up_cnt > 3'h4 && !reg_wr && reg_addr == 6'h01)[*3]
    |-> reg_rdata == {2'b00, chroma_filter_field, text_enhance_field, luma_filter_field})
    else $error("filter read layout");
  a_mode_read_back: assert property ((up_cnt > 3'h4 && !reg_wr && reg_addr == 6'h00)[*3]
    |-> reg_rdata == {input_resolution_code, output_standard_code, scaling_ratio_code})
    else $error("mode read back");
  a_invalid_totals_zero: assert property (!mode_valid |-> pixels_per_line == 11'h000 &&
    lines_per_frame == 10'h000 && pixel_clock_khz == 16'h0000) else $error("invalid totals");
  a_interlaced_clock: assert property (interlaced_mode |-> pixel_clock_khz == 16'h34bc &&
    scaling_ratio_code == TVM_SCL_1_1 && mode_number > 5'h18) else $error("interlaced mode");
  c_dot_crawl: cover property (s_wr_flt ##2 dot_crawl_reduce);
  c_interlaced: cover property (s_wr_mode ##2 interlaced_mode);
  c_invalid_mode: cover property (s_wr_mode ##2 !mode_valid);
endmodule : tvm_display_regs_assertions
bind tvm_display_regs tvm_display_regs_assertions u_chk (.*);

// ==== test/tb_tvm_display_regs.sv ====
`timescale 1ns/1ns
module tb_tvm_display_regs;
  import tvm_pkg::*;
  typedef struct packed {logic [7:0] code; logic [4:0] num; logic [10:0] ppl; logic [9:0] lpf;
    logic [15:0] khz;} tvm_tb_mode_t;
  tvm_tb_mode_t modes [10] = '{'{8'h00, 5'h00, 11'h348, 10'h1f4, 16'h5208},
    '{8'h20, 5'h04, 11'h465, 10'h1f4, 16'h6ddd}, '{8'h6a, 5'h11, 11'h310, 10'h258, 16'h6e24},
    '{8'h8b, 5'h16, 11'h410, 10'h276, 16'h9969}, '{8'h8d, 5'h18, 11'h428, 10'h2ee, 16'hbad8},
    '{8'ha1, 5'h19, 11'h360, 10'h271, 16'h34bc}, '{8'ha9, 5'h1a, 11'h35a, 10'h20d, 16'h34bc},
    '{8'h02, 5'h00, 11'h000, 10'h000, 16'h0000}, '{8'h71, 5'h00, 11'h000, 10'h000, 16'h0000},
    '{8'h79, 5'h00, 11'h000, 10'h000, 16'h0000}};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  tvm_res_t input_resolution_code;
  tvm_std_t output_standard_code;
  tvm_scale_t scaling_ratio_code;
  logic mode_valid, interlaced_mode, dot_crawl_reduce, filter_code_invalid;
  logic [4:0] mode_number;
  logic [10:0] pixels_per_line;
  logic [9:0] lines_per_frame;
  logic [15:0] pixel_clock_khz;
  tvm_flt_t chroma_filter_field, luma_filter_field, text_enhance_field;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  tvm_display_regs DUT (.*);
  always #5 ref_clk = ~ref_clk;
  task stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // Hang guard, far beyond the roughly 180 cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      stop_test();
    end
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      fails = fails + 1;
    end
  endtask : check
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : wr
  task rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    repeat (2) @(negedge ref_clk);
    check("rdata", reg_rdata, exp);
  endtask : rd
  task t_reset();
    rd(6'h00, 8'h6a);
    rd(6'h01, 8'h38);
    rd(6'h3f, 8'h00);
    check("mode", {mode_valid, mode_number, pixels_per_line}, {1'b1, 5'h11, 11'h310});
    check("lines", lines_per_frame, 16'h0258);
    check("khz", pixel_clock_khz, 16'h6e24);
    check("filters", {chroma_filter_field, luma_filter_field, text_enhance_field,
      dot_crawl_reduce, filter_code_invalid}, 16'h00ca);
    $display("done reset values");
  endtask : t_reset
  task t_modes();
    foreach (modes[i])
    begin
      wr(6'h00, modes[i].code);
      check("code", {input_resolution_code, output_standard_code, scaling_ratio_code},
        modes[i].code);
      check("valid", {mode_valid, interlaced_mode, mode_number}, {modes[i].ppl != 11'h000,
        modes[i].num > 5'h18, modes[i].num});
      check("ppl", pixels_per_line, modes[i].ppl);
      check("lpf", lines_per_frame, modes[i].lpf);
      check("khz", pixel_clock_khz, modes[i].khz);
      rd(6'h00, modes[i].code);
    end
    $display("done display modes");
  endtask : t_modes
  task t_filter();
    logic [1:0] cc;
    for (int c = 0; c < 4; c++)
    begin
      cc = c[1:0];
      wr(6'h01, {2'b11, cc, 4'b0110});
      check("chroma", {chroma_filter_field, dot_crawl_reduce}, {cc, cc == 2'b11});
      check("luma text", {luma_filter_field, text_enhance_field, filter_code_invalid},
        16'h000c);
      rd(6'h01, {2'b00, cc, 4'b1001});
    end
    wr(6'h01, 8'h0d);
    check("luma bad", filter_code_invalid, 16'h0001);
    rd(6'h01, 8'h07);
    wr(6'h01, 8'h03);
    check("text bad", filter_code_invalid, 16'h0001);
    rd(6'h01, 8'h0c);
    $display("done filter control");
  endtask : t_filter
  task t_unmapped();
    wr(6'h02, 8'hff);
    wr(6'h3f, 8'h00);
    rd(6'h00, 8'h79);
    rd(6'h01, 8'h0c);
    rd(6'h02, 8'h00);
    $display("done unmapped access");
  endtask : t_unmapped
  task t_midreset();
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_reset();
  endtask : t_midreset
  initial
  begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_reset();
    t_modes();
    t_filter();
    t_unmapped();
    t_midreset();
    stop_test();
  end
endmodule : tb_tvm_display_regs
